/* core/slgc_pkg.sv */
// Constants, types and register map of the serial link pin and clock block.
package slgc_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_REMOTE_SEL = 8'h0D;
  localparam logic [7:0] ADDR_PIN_DIR = 8'h0E;
  localparam logic [7:0] ADDR_CLK_CTRL = 8'h20;
  localparam logic [7:0] ADDR_FWD_CNT = 8'h21;
  localparam logic [7:0] ADDR_MODE_STS = 8'h22;
  localparam logic [7:0] ADDR_PIN_STS = 8'h53;

  // ****************************************************************
  // Reset values and field positions
  // ****************************************************************
  localparam logic [7:0] PIN_DIR_RESET = 8'h0F;
  localparam logic [7:0] REMOTE_SEL_RESET = 8'h00;
  localparam logic [7:0] CLK_CTRL_RESET = 8'h00;
  localparam logic [2:0] FWD_CNT_RESET = 3'h0;
  localparam int DIR_IN_LSB = 0;
  localparam int DIR_OUT_LSB = 4;
  localparam int SEL_LOCAL_LSB = 0;
  localparam int SEL_REMOTE_LSB = 4;
  localparam int CTRL_DIV_LSB = 0;
  localparam int CTRL_REFDIV_BIT = 2;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ = 125;
  localparam int FWD_LAT_NS = 225;
  localparam int FWD_LAT_CYC = (FWD_LAT_NS * CLK_MHZ + 999) / 1000;
  localparam logic [2:0] FRAMES_ONE_PIN = 3'h1;
  localparam logic [2:0] FRAMES_TWO_PIN = 3'h2;
  localparam logic [2:0] FRAMES_MANY_PIN = 3'h5;

  // ****************************************************************
  // Clock mode figures
  // ****************************************************************
  localparam logic [7:0] FWD_MULT_SYNC = 8'hA0;
  localparam logic [7:0] FWD_MULT_DIV1 = 8'h50;
  localparam logic [7:0] FWD_MULT_DIV2 = 8'h28;
  localparam logic [7:0] FWD_MULT_COMPAT = 8'h1C;
  localparam logic [7:0] CSI_MULT_SYNC = 8'h80;
  localparam logic [7:0] CSI_MULT_DIV1 = 8'h40;
  localparam logic [7:0] CSI_MULT_DIV2 = 8'h20;
  localparam logic [7:0] CSI_MULT_COMPAT = 8'h14;
  localparam logic [15:0] BC_KHZ10_SYNC = 16'h413C;
  localparam logic [15:0] BC_KHZ10_NONSYNC = 16'h0D0C;
  localparam logic [15:0] BC_KHZ10_COMPAT = 16'h0343;
  localparam logic [4:0] SENSOR_DIV_4 = 5'h04;
  localparam logic [4:0] SENSOR_DIV_8 = 5'h08;
  localparam logic [4:0] SENSOR_DIV_16 = 5'h10;

  typedef enum logic [2:0] {
    SLGC_MODE_SYNC = 3'b000,
    SLGC_MODE_EXT = 3'b010,
    SLGC_MODE_INT = 3'b011,
    SLGC_MODE_COMPAT = 3'b101
  } slgc_mode_t;

  typedef enum logic [1:0] {
    SLGC_REF_BACK = 2'b00,
    SLGC_REF_EXT = 2'b01,
    SLGC_REF_INT = 2'b10
  } slgc_ref_t;

  typedef struct packed {
    slgc_ref_t ref_source;
    logic [7:0] fwd_rate_mult;
    logic [7:0] csi_bw_mult;
    logic sensor_ref_en;
    logic [4:0] sensor_ref_divider;
    logic [15:0] bc_sample_khz10;
  } slgc_clk_cfg_t;

endpackage

/* core/slgc_top.sv */
// Pin direction, forward and back channel pin data, and clock mode logic.
// Overview of operation
// - All four pins are inputs after reset.
// - Input enables sit in direction bits 3:0.
// - Output enables sit in direction bits 7:4.
// - Up to four local pins are forwarded.
// - Sample every 1, 2 or 5 frames.
// - Forward latency stays short, one clock cycle, within the 225 ns bound.
// - Output pins may drive remote back channel data.
// - Back channel sample rate follows clock mode.
// - Clock mode comes from the mode strap.
// - Synchronous mode uses back channel reference, x160.
// - Synchronous mode feeds sensor reference from back channel.
// - External mode uses input divider, x80 or x40.
// - Status register shows every pin level.
`timescale 1ns/1ps

module slgc_top #(
  parameter int PINS = 4
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe,
  input wire logic [2:0] mode_strap,
  input wire logic fwd_frame_tick,
  output logic [PINS-1:0] fwd_pin_data,
  output logic fwd_pin_valid,
  input wire logic bc_sample_valid,
  input wire logic [PINS-1:0] bc_pin_data,
  output slgc_pkg::slgc_mode_t clk_mode,
  output slgc_pkg::slgc_clk_cfg_t clk_cfg
);

  // ****************************************************************
  // Reset release and synchronisers
  // ****************************************************************
  logic [1:0] rst_sync;
  logic rst_n;
  logic [PINS-1:0] pin_meta;
  logic [PINS-1:0] pin_level;
  logic [2:0] strap_meta;
  logic [2:0] strap_sync;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // Pins and the strap arrive from outside, so only the second stage is read.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta <= '0;
      pin_level <= '0;
      strap_meta <= 3'h0;
      strap_sync <= 3'h0;
    end
    else if (clk_en)
    begin
      pin_meta <= pin_in;
      pin_level <= pin_meta;
      strap_meta <= mode_strap;
      strap_sync <= strap_meta;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] pin_direction_control;
  logic [7:0] pin_remote_data_select;
  logic [7:0] clock_control;
  logic [2:0] forward_pin_count;
  logic [PINS-1:0] in_en;
  logic [PINS-1:0] out_en;
  logic [PINS-1:0] local_val;
  logic [PINS-1:0] remote_en;
  logic [1:0] div_code;
  logic ref_input_divider;
  logic [7:0] next_rdata;
  logic wr_dir;
  logic wr_sel;
  logic wr_ctrl;
  logic wr_cnt;

  assign wr_dir = reg_wr && reg_addr == slgc_pkg::ADDR_PIN_DIR;
  assign wr_sel = reg_wr && reg_addr == slgc_pkg::ADDR_REMOTE_SEL;
  assign wr_ctrl = reg_wr && reg_addr == slgc_pkg::ADDR_CLK_CTRL;
  assign wr_cnt = reg_wr && reg_addr == slgc_pkg::ADDR_FWD_CNT;

  assign in_en = pin_direction_control[slgc_pkg::DIR_IN_LSB +: PINS];
  assign out_en = pin_direction_control[slgc_pkg::DIR_OUT_LSB +: PINS];
  assign local_val = pin_remote_data_select[slgc_pkg::SEL_LOCAL_LSB +: PINS];
  assign remote_en = pin_remote_data_select[slgc_pkg::SEL_REMOTE_LSB +: PINS];
  assign div_code = clock_control[slgc_pkg::CTRL_DIV_LSB +: 2];
  assign ref_input_divider = clock_control[slgc_pkg::CTRL_REFDIV_BIT];

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_direction_control <= slgc_pkg::PIN_DIR_RESET;
      pin_remote_data_select <= slgc_pkg::REMOTE_SEL_RESET;
      clock_control <= slgc_pkg::CLK_CTRL_RESET;
      forward_pin_count <= slgc_pkg::FWD_CNT_RESET;
    end
    else if (clk_en)
    begin
      if (wr_dir)
        pin_direction_control <= reg_wdata;
      if (wr_sel)
        pin_remote_data_select <= reg_wdata;
      if (wr_ctrl)
        clock_control <= {5'h00, reg_wdata[2:0]};
      if (wr_cnt)
        forward_pin_count <= reg_wdata[2:0];
    end
  end

  // Unmapped offsets read as zero.
  always_comb
  begin
    next_rdata = 8'h00;
    unique case (reg_addr)
      slgc_pkg::ADDR_PIN_DIR: next_rdata = pin_direction_control;
      slgc_pkg::ADDR_REMOTE_SEL: next_rdata = pin_remote_data_select;
      slgc_pkg::ADDR_CLK_CTRL: next_rdata = clock_control;
      slgc_pkg::ADDR_FWD_CNT: next_rdata = {5'h00, forward_pin_count};
      slgc_pkg::ADDR_MODE_STS: next_rdata = {5'h00, clk_mode};
      slgc_pkg::ADDR_PIN_STS: next_rdata = 8'(pin_level);
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else if (clk_en)
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= next_rdata;
    end
  end

  // ****************************************************************
  // Pin drive from local or remote data
  // ****************************************************************
  logic [PINS-1:0] bc_hold;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      bc_hold <= '0;
    else if (clk_en && bc_sample_valid)
      bc_hold <= bc_pin_data;
  end

  // A pin with both enables set stays undriven rather than fight the pad.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_out <= '0;
      pin_oe <= '0;
    end
    else if (clk_en)
    begin
      pin_oe <= out_en & ~in_en;
      pin_out <= (remote_en & bc_hold) | (~remote_en & local_val);
    end
  end

  // ****************************************************************
  // Forward channel pin sampling
  // ****************************************************************
  logic [2:0] frame_period;
  logic [2:0] frame_cnt;
  logic [PINS-1:0] fwd_mask;
  logic sample_due;

  assign frame_period = forward_pin_count == 3'h1 ? slgc_pkg::FRAMES_ONE_PIN
    : forward_pin_count == 3'h2 ? slgc_pkg::FRAMES_TWO_PIN
    : slgc_pkg::FRAMES_MANY_PIN;
  assign fwd_mask = PINS'((5'h01 << forward_pin_count) - 5'h01);
  assign sample_due = fwd_frame_tick && forward_pin_count != 3'h0
    && forward_pin_count <= 3'(PINS) && frame_cnt == frame_period - 3'h1;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frame_cnt <= 3'h0;
      fwd_pin_data <= '0;
      fwd_pin_valid <= 1'b0;
    end
    else if (clk_en)
    begin
      fwd_pin_valid <= sample_due;
      if (wr_cnt || sample_due)
        frame_cnt <= 3'h0;
      else if (fwd_frame_tick)
        frame_cnt <= frame_cnt + 3'h1;
      if (sample_due)
        fwd_pin_data <= pin_level & in_en & fwd_mask;
    end
  end

  // ****************************************************************
  // Clock mode
  // ****************************************************************
  logic strap_taken;
  logic [1:0] strap_fill;
  slgc_pkg::slgc_clk_cfg_t next_cfg;

  // The strap is caught once, after both synchroniser stages have filled
  // following reset release, so a stale reset value is never latched.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_fill <= 2'h0;
      strap_taken <= 1'b0;
      clk_mode <= slgc_pkg::SLGC_MODE_SYNC;
    end
    else if (clk_en && !strap_taken)
    begin
      strap_fill <= {strap_fill[0], 1'b1};
      strap_taken <= strap_fill[1];
      clk_mode <= slgc_pkg::slgc_mode_t'(strap_sync);
    end
  end

  always_comb
  begin
    next_cfg = '0;
    next_cfg.sensor_ref_en = 1'b1;
    next_cfg.sensor_ref_divider = div_code == 2'h1 ? slgc_pkg::SENSOR_DIV_8
      : div_code == 2'h2 ? slgc_pkg::SENSOR_DIV_16
      : slgc_pkg::SENSOR_DIV_4;
    next_cfg.bc_sample_khz10 = slgc_pkg::BC_KHZ10_NONSYNC;
    next_cfg.ref_source = slgc_pkg::SLGC_REF_EXT;
    next_cfg.fwd_rate_mult = ref_input_divider ? slgc_pkg::FWD_MULT_DIV2
      : slgc_pkg::FWD_MULT_DIV1;
    next_cfg.csi_bw_mult = ref_input_divider ? slgc_pkg::CSI_MULT_DIV2
      : slgc_pkg::CSI_MULT_DIV1;
    unique case (clk_mode)
      slgc_pkg::SLGC_MODE_SYNC:
      begin
        next_cfg.ref_source = slgc_pkg::SLGC_REF_BACK;
        next_cfg.fwd_rate_mult = slgc_pkg::FWD_MULT_SYNC;
        next_cfg.csi_bw_mult = slgc_pkg::CSI_MULT_SYNC;
        next_cfg.bc_sample_khz10 = slgc_pkg::BC_KHZ10_SYNC;
      end
      slgc_pkg::SLGC_MODE_EXT: next_cfg.ref_source = slgc_pkg::SLGC_REF_EXT;
      slgc_pkg::SLGC_MODE_INT:
      begin
        next_cfg.ref_source = slgc_pkg::SLGC_REF_INT;
        next_cfg.fwd_rate_mult = slgc_pkg::FWD_MULT_DIV1;
        next_cfg.csi_bw_mult = slgc_pkg::CSI_MULT_DIV1;
        next_cfg.sensor_ref_en = 1'b0;
      end
      slgc_pkg::SLGC_MODE_COMPAT:
      begin
        next_cfg.fwd_rate_mult = slgc_pkg::FWD_MULT_COMPAT;
        next_cfg.csi_bw_mult = slgc_pkg::CSI_MULT_COMPAT;
        next_cfg.bc_sample_khz10 = slgc_pkg::BC_KHZ10_COMPAT;
      end
      default: next_cfg.ref_source = slgc_pkg::SLGC_REF_BACK;
    endcase
  end

  // In synchronous mode the sensor reference is derived from the back channel.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      clk_cfg <= '0;
    else if (clk_en)
      clk_cfg <= next_cfg;
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  localparam int FWD_LAT_BOUND = slgc_pkg::FWD_LAT_CYC;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  pins_input_reset_a: assert property (
    $rose(rst_n) |-> pin_direction_control == slgc_pkg::PIN_DIR_RESET)
    else $error("Pins are not inputs after reset.");
  in_enable_bits_a: assert property (
    clk_en && wr_dir |=> in_en == $past(reg_wdata[3:0]))
    else $error("Input enable field not written.");
  oe_follows_dir_a: assert property (
    clk_en && wr_dir ##1 clk_en |=> pin_oe == ($past(reg_wdata[7:4], 2)
      & ~$past(reg_wdata[3:0], 2)))
    else $error("Output enable does not follow direction bits.");
  fwd_one_frame_a: assert property (
    clk_en && forward_pin_count == 3'h1 && fwd_frame_tick |=> fwd_pin_valid)
    else $error("One forwarded pin missed a frame.");
  fwd_latency_a: assert property (
    clk_en && sample_due |-> ##[1:FWD_LAT_BOUND] fwd_pin_valid)
    else $error("Forwarded sample later than latency bound.");
  fwd_masked_a: assert property (
    fwd_pin_valid |-> (fwd_pin_data & ~$past(in_en)) == '0)
    else $error("Forwarded data from a non input pin.");
  remote_drive_a: assert property (
    clk_en && remote_en == '1 && !wr_sel |=> pin_out == $past(bc_hold))
    else $error("Remote data not driven on the pin.");
  bc_hold_a: assert property (
    clk_en && !bc_sample_valid |=> bc_hold == $past(bc_hold))
    else $error("Remote pin value changed without a sample.");
  sync_mode_cfg_a: assert property (
    clk_en && clk_mode == slgc_pkg::SLGC_MODE_SYNC |=>
      clk_cfg.fwd_rate_mult == slgc_pkg::FWD_MULT_SYNC
      && clk_cfg.ref_source == slgc_pkg::SLGC_REF_BACK)
    else $error("Synchronous mode configuration wrong.");
  status_level_a: assert property (
    clk_en && reg_rd && reg_addr == slgc_pkg::ADDR_PIN_STS |=>
      reg_rvalid && reg_rdata[PINS-1:0] == $past(pin_level))
    else $error("Pin status read does not show pin levels.");

endmodule

/* testbench/slgc_far_model.sv */
// Far side stand-in: forward frame ticks and back channel pin samples.
`timescale 1ns/1ps

module slgc_far_model #(
  parameter int GAP = 3
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic tick_en,
  input wire logic bc_go,
  input wire logic [3:0] bc_val,
  output logic fwd_frame_tick = 1'b0,
  output logic bc_sample_valid = 1'b0,
  output logic [3:0] bc_pin_data = 4'h0
);
  int cnt = 0;

  // ********************
  // Frames and samples
  // ********************
  // Between samples the data lines toggle every cycle, so a design that
  // rereads them instead of holding its last sample is caught.
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt <= 0;
      fwd_frame_tick <= 1'b0;
      bc_sample_valid <= 1'b0;
    end
    else
    begin
      cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
      fwd_frame_tick <= tick_en && cnt == GAP - 1;
      bc_sample_valid <= bc_go;
      bc_pin_data <= bc_go ? bc_val : ~bc_pin_data;
    end
  end
endmodule

/* testbench/slgc_top_tb.sv */
// Self-checking bench for the pin direction, pin data and clock modes.
`timescale 1ns/1ps

module slgc_top_tb;
  localparam logic [2:0] MD[5] = '{3'h0, 3'h2, 3'h2, 3'h3, 3'h5};
  localparam int REF[5] = '{0, 1, 1, 2, 1};
  localparam int FWD[5] = '{160, 80, 40, 80, 28};
  localparam int CSI[5] = '{128, 64, 32, 64, 20};
  localparam int BCK[5] = '{16700, 3340, 3340, 3340, 835};
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [2:0] mode_strap = 3'h0;
  logic tick_en = 1'b0;
  logic bc_go = 1'b0;
  logic [3:0] bc_val = 4'h0;
  logic [3:0] ext_lvl = 4'h0;
  logic [3:0] fmask = 4'h0;
  logic [3:0] e;
  logic [7:0] d, reg_rdata;
  logic [3:0] pin_in, pin_out, pin_oe, fwd_pin_data, bc_pin_data;
  logic reg_rvalid, fwd_frame_tick, fwd_pin_valid, bc_sample_valid;
  slgc_pkg::slgc_mode_t clk_mode;
  slgc_pkg::slgc_clk_cfg_t clk_cfg;
  int err_count = 0;
  int checks = 0;
  int per = 0;
  int ticks = 0;
  int since = 0;
  int valids = 0;
  int n, r;

  // Pads show the driven value where enabled, the outside level elsewhere.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);

  initial
  begin
    forever #4 clk_sys = ~clk_sys;
  end

  slgc_top dut (.clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .mode_strap(mode_strap), .fwd_frame_tick(fwd_frame_tick),
    .fwd_pin_data(fwd_pin_data), .fwd_pin_valid(fwd_pin_valid),
    .bc_sample_valid(bc_sample_valid), .bc_pin_data(bc_pin_data),
    .clk_mode(clk_mode), .clk_cfg(clk_cfg));

  slgc_far_model #(.GAP(3)) far (.clk_sys(clk_sys), .rstn(rstn),
    .tick_en(tick_en), .bc_go(bc_go), .bc_val(bc_val),
    .fwd_frame_tick(fwd_frame_tick), .bc_sample_valid(bc_sample_valid),
    .bc_pin_data(bc_pin_data));

  // ********************
  // Shared tasks
  // ********************
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  // A strobe is lowered and a full cycle passes, so calls may follow.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_rd = 1'b1;
    reg_addr = a;
    cyc(1);
    reg_rd = 1'b0;
    chk(reg_rvalid, 1'b1);
    chk(reg_rdata, exp);
    cyc(1);
  endtask

  task automatic do_reset();
    rstn = 1'b0;
    cyc(8);
    rstn = 1'b1;
    cyc(8);
  endtask

  // ********************
  // Forward sample model
  // ********************
  // Counts frames between samples and cycles since the last tick.
  always @(posedge clk_sys)
  begin
    if (fwd_pin_valid)
    begin
      valids++;
      chk(since, 0);
      chk(ticks, per);
      chk(fwd_pin_data, ext_lvl & fmask);
      ticks = 0;
    end
    if (fwd_frame_tick)
    begin
      ticks++;
      since = 0;
    end
    else
      since++;
  end

  initial
  begin
    r = $urandom(75334);
    for (n = 0; n < 5; n++)
    begin
      mode_strap = MD[n];
      do_reset();
      chk(pin_oe, 4'h0);
      rd(8'h0E, 8'h0F);
      rd(8'h0D, 8'h00);
      rd(8'h7F, 8'h00);
      wr(8'h20, {5'h00, n == 2, n == 3 ? 2'h3 : 2'(n % 3)});
      cyc(2);
      chk(clk_mode, MD[n]);
      chk(clk_cfg.ref_source, REF[n]);
      chk(clk_cfg.fwd_rate_mult, FWD[n]);
      chk(clk_cfg.csi_bw_mult, CSI[n]);
      chk(clk_cfg.sensor_ref_en, n != 3);
      chk(clk_cfg.sensor_ref_divider, 4 << (n % 3));
      chk(clk_cfg.bc_sample_khz10, BCK[n]);
      chk(clk_cfg.csi_bw_mult < clk_cfg.fwd_rate_mult, 1'b1);
      rd(8'h22, {5'h00, MD[n]});
    end
    for (n = 0; n < 8; n++)
    begin
      d = (n == 0) ? 8'hFF : 8'($urandom);
      wr(8'h0E, d);
      chk(pin_oe, d[7:4] & ~d[3:0]);
      rd(8'h0E, d);
    end
    for (n = 0; n <= 5; n++)
    begin
      ext_lvl = 4'($urandom);
      d = {4'h0, 4'($urandom)};
      wr(8'h0E, d);
      wr(8'h21, 8'(n));
      per = (n == 1) ? 1 : (n == 2) ? 2 : (n == 3 || n == 4) ? 5 : 0;
      fmask = 4'((1 << n) - 1) & d[3:0];
      ticks = 0;
      valids = 0;
      rd(8'h53, {4'h0, ext_lvl});
      tick_en = 1'b1;
      cyc(60);
      tick_en = 1'b0;
      cyc(4);
      chk(valids == 0, per == 0);
    end
    // A write while the clock enable is low must leave the register alone.
    clk_en = 1'b0;
    wr(8'h0D, 8'hFF);
    clk_en = 1'b1;
    rd(8'h0D, 8'h00);
    wr(8'h0E, 8'hF0);
    for (n = 0; n < 8; n++)
    begin
      d = 8'($urandom);
      bc_val = 4'($urandom);
      e = (d[7:4] & bc_val) | (~d[7:4] & d[3:0]);
      wr(8'h0D, d);
      bc_go = 1'b1;
      cyc(1);
      bc_go = 1'b0;
      cyc(3);
      chk(pin_oe, 4'hF);
      chk(pin_out, e);
      cyc(5);
      chk(pin_out, e);
      rd(8'h53, {4'h0, e});
      rd(8'h0D, d);
    end
    wrap_up();
  end
endmodule
